// file: rtl/status_consts.svh
`ifndef STATUS_CONSTS_SVH
`define STATUS_CONSTS_SVH
// Summary of operation
// - Reading a group's event part returns its latched bits, then clears them.
// - Reading a group's condition part has no side effect on it.
// - Operation condition part shows the monitored hardware signals live, unlatched.
// - Rising-transition mask (0..32767 by write, 65535 after preset) picks bits whose 0-to-1 change sets events.
// - Falling-transition mask (0..32767) picks bits whose 1-to-0 change sets events.
// - Per-group enable mask picks event bits feeding that group's summary bit.
// - Preset loads every rising-transition mask with all ones.
// - Preset clears every falling-transition mask to zero.
// - Preset clears the enable masks of both groups.
// - Instrument reset command leaves every status group register unchanged.
// - Error queue read returns oldest entry and removes it, first in first out.
// - Error queue read when empty returns code zero, meaning no error.
// - Error codes are signed; positive instrument-specific, negative standard-defined.
`define SER_REG_W 16
`define SER_COND_W 15
`define SER_WR_MASK 16'h7fff
`define SER_PTR_PRESET 16'hffff
`define SER_NTR_PRESET 16'h0000
`define SER_ENA_PRESET 16'h0000
`define SER_EVT_CLEAR 16'h0000
`define SER_NO_ERROR 16'h0000
`define SER_ERRQ_DEPTH 8
`endif

// file: rtl/status_event_reporting.sv
`include "status_consts.svh"
module status_event_reporting
	import status_pkg::*;
#(
	parameter int COND_W = `SER_COND_W,
	parameter int ERRQ_DEPTH = `SER_ERRQ_DEPTH
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Monitored hardware conditions
	input wire logic [COND_W-1:0] i_oper_cond,
	input wire logic [COND_W-1:0] i_ques_cond,
	// Command from the software interface
	input wire logic i_cmd_valid,
	input wire op_t i_cmd_op,
	input wire logic i_cmd_ques,
	input wire logic [`SER_REG_W-1:0] i_cmd_data,
	// Error entries from the instrument
	input wire logic i_err_push,
	input wire err_code_t i_err_code,
	// Query answers
	output logic o_resp_valid,
	output logic [`SER_REG_W-1:0] o_resp_data,
	// Summary bits and queue state
	output logic o_oper_sum,
	output logic o_ques_sum,
	output logic o_err_empty,
	output logic o_err_full
);
	localparam int AW = (ERRQ_DEPTH > 1) ? $clog2(ERRQ_DEPTH) : 1;
	localparam int CW = $clog2(ERRQ_DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(ERRQ_DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(ERRQ_DEPTH - 1);

	status_grp_if oper_if ();
	status_grp_if ques_if ();

	logic sel_oper;
	logic sel_ques;
	logic is_read;
	logic pop;
	logic push;
	err_code_t queue [ERRQ_DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [`SER_REG_W-1:0] next_resp_data;
	reg_t grp_evt;
	reg_t grp_cond;
	reg_t grp_ptr;
	reg_t grp_ntr;
	reg_t grp_ena;

	status_group #(
		.COND_W(COND_W)
	) u_oper (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_cond(i_oper_cond),
		.bus(oper_if.grp)
	);

	status_group #(
		.COND_W(COND_W)
	) u_ques (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_cond(i_ques_cond),
		.bus(ques_if.grp)
	);

	// Command decode; instrument reset reaches no group strobe
	assign sel_oper = i_cmd_valid && !i_cmd_ques;
	assign sel_ques = i_cmd_valid && i_cmd_ques;

	assign oper_if.wr_ptr = sel_oper && (i_cmd_op == OP_WR_PTR);
	assign oper_if.wr_ntr = sel_oper && (i_cmd_op == OP_WR_NTR);
	assign oper_if.wr_ena = sel_oper && (i_cmd_op == OP_WR_ENA);
	assign oper_if.rd_evt = sel_oper && (i_cmd_op == OP_RD_EVT);
	assign oper_if.preset = i_cmd_valid && (i_cmd_op == OP_PRESET);
	assign oper_if.wdata = i_cmd_data;

	assign ques_if.wr_ptr = sel_ques && (i_cmd_op == OP_WR_PTR);
	assign ques_if.wr_ntr = sel_ques && (i_cmd_op == OP_WR_NTR);
	assign ques_if.wr_ena = sel_ques && (i_cmd_op == OP_WR_ENA);
	assign ques_if.rd_evt = sel_ques && (i_cmd_op == OP_RD_EVT);
	assign ques_if.preset = i_cmd_valid && (i_cmd_op == OP_PRESET);
	assign ques_if.wdata = i_cmd_data;

	// Group view for the answer mux
	assign grp_evt = i_cmd_ques ? ques_if.evt : oper_if.evt;
	assign grp_cond = i_cmd_ques ? ques_if.cond : oper_if.cond;
	assign grp_ptr = i_cmd_ques ? ques_if.ptr : oper_if.ptr;
	assign grp_ntr = i_cmd_ques ? ques_if.ntr : oper_if.ntr;
	assign grp_ena = i_cmd_ques ? ques_if.ena : oper_if.ena;

	// Error queue pointers
	assign pop = i_cmd_valid && (i_cmd_op == OP_RD_ERR) && (count != '0);
	// Full queue drops the newest entry unless a read frees a slot
	assign push = i_err_push && ((count != DEPTH_C) || pop);

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + CW'(1);
		end else if (pop && !push) begin
			next_count = count - CW'(1);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
		end else begin
			count <= next_count;
			if (push) begin
				wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + AW'(1);
			end
			if (pop) begin
				rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + AW'(1);
			end
		end
	end

	// Storage needs no reset; count guards every read
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			queue[wr_idx] <= i_err_code;
		end
	end

	// Answer mux
	always_comb begin
		is_read = 1'b0;
		next_resp_data = '0;
		case (i_cmd_op)
			OP_RD_EVT: begin
				is_read = 1'b1;
				next_resp_data = grp_evt;
			end
			OP_RD_COND: begin
				is_read = 1'b1;
				next_resp_data = grp_cond;
			end
			OP_RD_PTR: begin
				is_read = 1'b1;
				next_resp_data = grp_ptr;
			end
			OP_RD_NTR: begin
				is_read = 1'b1;
				next_resp_data = grp_ntr;
			end
			OP_RD_ENA: begin
				is_read = 1'b1;
				next_resp_data = grp_ena;
			end
			OP_RD_ERR: begin
				is_read = 1'b1;
				next_resp_data = (count == '0) ? `SER_NO_ERROR : queue[rd_idx];
			end
			default: begin
				is_read = 1'b0;
				next_resp_data = '0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_resp_valid <= 1'b0;
			o_resp_data <= '0;
		end else begin
			o_resp_valid <= i_cmd_valid && is_read;
			if (i_cmd_valid && is_read) begin
				o_resp_data <= next_resp_data;
			end
		end
	end

	// Registered summary adds one cycle so outputs leave a flop
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_oper_sum <= 1'b0;
			o_ques_sum <= 1'b0;
		end else begin
			o_oper_sum <= oper_if.summary;
			o_ques_sum <= ques_if.summary;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_err_empty <= 1'b1;
			o_err_full <= 1'b0;
		end else begin
			o_err_empty <= (next_count == '0);
			o_err_full <= (next_count == DEPTH_C);
		end
	end

	a_summary_follows: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		##1 (o_oper_sum == $past(|(oper_if.evt & oper_if.ena))) && (o_ques_sum == $past(|(ques_if.evt & ques_if.ena))))
		else $error("summary bit does not match masked events");
	a_masked_summary: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(oper_if.ena == '0) |=> !o_oper_sum)
		else $error("summary set with enable mask clear");
	a_inst_rst_keep: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_cmd_valid && i_cmd_op == OP_INST_RST) |=> $stable(oper_if.ptr) && $stable(oper_if.ntr)
			&& $stable(oper_if.ena) && $stable(ques_if.ptr) && $stable(ques_if.ntr) && $stable(ques_if.ena)
			&& (($past(oper_if.evt) & ~oper_if.evt) == '0))
		else $error("instrument reset changed status registers");
	a_cond_read_keep: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_cmd_valid && i_cmd_op == OP_RD_COND) |=> o_resp_valid && (o_resp_data == $past(grp_cond))
			&& $stable(oper_if.ptr) && (($past(oper_if.evt) & ~oper_if.evt) == '0)
			&& (($past(ques_if.evt) & ~ques_if.evt) == '0))
		else $error("condition read wrong or had side effect");
	a_evt_read_value: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_cmd_valid && i_cmd_op == OP_RD_EVT) |=> o_resp_valid && (o_resp_data == $past(grp_evt)))
		else $error("event read returned wrong value");
	a_err_empty_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_cmd_valid && i_cmd_op == OP_RD_ERR && count == '0) |=> o_resp_valid && (o_resp_data == `SER_NO_ERROR))
		else $error("empty error queue did not return zero");
	a_err_fifo_pop: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(pop && !push) |=> (o_resp_data == $past(queue[rd_idx])) && (count == $past(count) - CW'(1)))
		else $error("error queue read not oldest or not removed");
	a_err_one_entry: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_err_push && count == '0 && !i_cmd_valid) ##1 (i_cmd_valid && i_cmd_op == OP_RD_ERR && !i_err_push)
			|=> $signed(o_resp_data) == $past(i_err_code, 2))
		else $error("signed error code not returned as stored");

	c_oper_event_read: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(oper_if.evt != '0) ##1 (i_cmd_valid && i_cmd_op == OP_RD_EVT && !i_cmd_ques));
	c_summary_raised: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		$rose(o_ques_sum));
	c_preset_done: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_cmd_valid && i_cmd_op == OP_PRESET);
	c_queue_full_pop: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_err_full ##1 pop);
endmodule : status_event_reporting

// file: rtl/status_group.sv
`include "status_consts.svh"
module status_group
	import status_pkg::*;
#(
	parameter int COND_W = `SER_COND_W
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Hardware condition pins
	input wire logic [COND_W-1:0] i_cond,
	// Control from the command decoder
	status_grp_if.grp bus
);
	logic [COND_W-1:0] cond_meta;
	logic [COND_W-1:0] cond_live;
	logic [COND_W-1:0] cond_prev;
	reg_t cond_w;
	reg_t prev_w;
	reg_t rise;
	reg_t fall;
	reg_t set_vec;
	reg_t ptr;
	reg_t ntr;
	reg_t ena;
	reg_t evt;

	// Pins are asynchronous to the clock
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			cond_meta <= '0;
			cond_live <= '0;
		end else begin
			cond_meta <= i_cond;
			cond_live <= cond_meta;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			cond_prev <= '0;
		end else begin
			cond_prev <= cond_live;
		end
	end

	assign cond_w = {{(`SER_REG_W-COND_W){1'b0}}, cond_live};
	assign prev_w = {{(`SER_REG_W-COND_W){1'b0}}, cond_prev};
	assign rise = cond_w & ~prev_w & ptr;
	assign fall = ~cond_w & prev_w & ntr;
	assign set_vec = rise | fall;

	// Writes only reach bits 14..0; preset may load bit 15 of the rising mask
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ptr <= `SER_PTR_PRESET;
			ntr <= `SER_NTR_PRESET;
			ena <= `SER_ENA_PRESET;
		end else if (bus.preset) begin
			ptr <= `SER_PTR_PRESET;
			ntr <= `SER_NTR_PRESET;
			ena <= `SER_ENA_PRESET;
		end else begin
			if (bus.wr_ptr) begin
				ptr <= bus.wdata & `SER_WR_MASK;
			end
			if (bus.wr_ntr) begin
				ntr <= bus.wdata & `SER_WR_MASK;
			end
			if (bus.wr_ena) begin
				ena <= bus.wdata & `SER_WR_MASK;
			end
		end
	end

	// A transition in the read cycle survives the clear
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			evt <= `SER_EVT_CLEAR;
		end else if (bus.rd_evt) begin
			evt <= set_vec;
		end else begin
			evt <= evt | set_vec;
		end
	end

	assign bus.cond = cond_w;
	assign bus.evt = evt;
	assign bus.ptr = ptr;
	assign bus.ntr = ntr;
	assign bus.ena = ena;
	assign bus.summary = |(evt & ena);

	a_evt_read_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		bus.rd_evt |=> (evt == $past(set_vec)))
		else $error("event part not cleared by read");
	a_rise_capture: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(|rise) |=> ((evt & $past(rise)) == $past(rise)))
		else $error("rising transition not captured");
	a_fall_capture: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(|fall) |=> ((evt & $past(fall)) == $past(fall)))
		else $error("falling transition not captured");
	a_evt_sticky_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		!bus.rd_evt |=> ((evt & $past(evt)) == $past(evt)))
		else $error("event bit lost without read");
	a_preset_masks: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		bus.preset |=> (ptr == `SER_PTR_PRESET) && (ntr == `SER_NTR_PRESET) && (ena == `SER_ENA_PRESET))
		else $error("preset values not loaded");
	a_no_spurious_evt: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!bus.rd_evt && set_vec == '0) |=> (evt == $past(evt)))
		else $error("event bit set without qualified transition");
endmodule : status_group

// file: rtl/status_grp_if.sv
interface status_grp_if;
	import status_pkg::*;
	logic wr_ptr;
	logic wr_ntr;
	logic wr_ena;
	logic preset;
	logic rd_evt;
	reg_t wdata;
	reg_t cond;
	reg_t evt;
	reg_t ptr;
	reg_t ntr;
	reg_t ena;
	logic summary;
	modport ctrl (output wr_ptr, wr_ntr, wr_ena, preset, rd_evt, wdata,
		input cond, evt, ptr, ntr, ena, summary);
	modport grp (input wr_ptr, wr_ntr, wr_ena, preset, rd_evt, wdata,
		output cond, evt, ptr, ntr, ena, summary);
endinterface : status_grp_if

// file: rtl/status_pkg.sv
`include "status_consts.svh"
package status_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_RD_EVT = 4'h1,
		OP_RD_COND = 4'h2,
		OP_RD_PTR = 4'h3,
		OP_RD_NTR = 4'h4,
		OP_RD_ENA = 4'h5,
		OP_WR_PTR = 4'h6,
		OP_WR_NTR = 4'h7,
		OP_WR_ENA = 4'h8,
		OP_PRESET = 4'h9,
		OP_RD_ERR = 4'ha,
		OP_INST_RST = 4'hb
	} op_t;
	typedef logic [`SER_REG_W-1:0] reg_t;
	typedef logic signed [`SER_REG_W-1:0] err_code_t;
endpackage : status_pkg

// file: verification/status_event_reporting_tb.sv
module status_event_reporting_tb
	import status_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// Small queue keeps the fill-and-drain short
	localparam int DEPTH = 4;

	logic i_ref_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [14:0] i_oper_cond = 15'h0000;
	logic [14:0] i_ques_cond = 15'h0000;
	logic i_cmd_valid = 1'b0;
	op_t i_cmd_op = OP_NONE;
	logic i_cmd_ques = 1'b0;
	logic [15:0] i_cmd_data = 16'h0000;
	logic i_err_push = 1'b0;
	err_code_t i_err_code = 16'h0000;
	logic o_resp_valid;
	logic [15:0] o_resp_data;
	logic o_oper_sum;
	logic o_ques_sum;
	logic o_err_empty;
	logic o_err_full;
	int mismatches = 0;
	int tests_run = 0;

	status_event_reporting #(.COND_W(15), .ERRQ_DEPTH(DEPTH)) uut (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_oper_cond(i_oper_cond),
		.i_ques_cond(i_ques_cond),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_op(i_cmd_op),
		.i_cmd_ques(i_cmd_ques),
		.i_cmd_data(i_cmd_data),
		.i_err_push(i_err_push),
		.i_err_code(i_err_code),
		.o_resp_valid(o_resp_valid),
		.o_resp_data(o_resp_data),
		.o_oper_sum(o_oper_sum),
		.o_ques_sum(o_ques_sum),
		.o_err_empty(o_err_empty),
		.o_err_full(o_err_full)
	);

	always #5 i_ref_clk = ~i_ref_clk;

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic cycles(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : cycles

	// Inputs move 1 ns after the edge, so the answer is settled on return
	task automatic cmd(input op_t op, input logic q, input logic [15:0] d);
		@(posedge i_ref_clk);
		#1;
		i_cmd_valid = 1'b1;
		i_cmd_op = op;
		i_cmd_ques = q;
		i_cmd_data = d;
		@(posedge i_ref_clk);
		#1;
		i_cmd_valid = 1'b0;
		i_cmd_op = OP_NONE;
	endtask : cmd

	task automatic rd(input op_t op, input logic q, input logic [15:0] exp, input string what);
		cmd(op, q, 16'h0000);
		check({15'h0000, o_resp_valid}, 16'h0001, "answer strobe");
		check(o_resp_data, exp, what);
	endtask : rd

	task automatic push(input err_code_t code);
		@(posedge i_ref_clk);
		#1;
		i_err_push = 1'b1;
		i_err_code = code;
		@(posedge i_ref_clk);
		#1;
		i_err_push = 1'b0;
	endtask : push

	function automatic logic [15:0] code_of(input int k);
		return k[0] ? 16'(-(100 + k)) : 16'(k + 1);
	endfunction : code_of

	task automatic t_reset;
		check({15'h0000, o_err_empty}, 16'h0001, "empty after reset");
		check({15'h0000, o_err_full}, 16'h0000, "full after reset");
		check({14'h0000, o_oper_sum, o_ques_sum}, 16'h0000, "sums after reset");
		for (int q = 0; q < 2; q++) begin
			rd(OP_RD_PTR, q[0], 16'hffff, "rising mask at reset");
			rd(OP_RD_NTR, q[0], 16'h0000, "falling mask at reset");
			rd(OP_RD_ENA, q[0], 16'h0000, "enable at reset");
		end
		$display("test reset done");
	endtask : t_reset

	task automatic t_rise;
		i_oper_cond = 15'h0011;
		cycles(5);
		rd(OP_RD_COND, 1'b0, 16'h0011, "live condition");
		rd(OP_RD_COND, 1'b0, 16'h0011, "condition after read");
		rd(OP_RD_EVT, 1'b0, 16'h0011, "rising events");
		rd(OP_RD_EVT, 1'b0, 16'h0000, "events cleared by read");
		i_oper_cond = 15'h0000;
		cycles(5);
		rd(OP_RD_EVT, 1'b0, 16'h0000, "falling ignored");
		rd(OP_RD_COND, 1'b0, 16'h0000, "condition follows pins");
		// Short high pulse: the event must outlive the pin
		i_oper_cond = 15'h0004;
		cycles(4);
		i_oper_cond = 15'h0000;
		cycles(5);
		rd(OP_RD_EVT, 1'b0, 16'h0004, "sticky event");
		$display("test rise done");
	endtask : t_rise

	task automatic t_fall;
		cmd(OP_WR_PTR, 1'b1, 16'h0000);
		cmd(OP_WR_NTR, 1'b1, 16'hffff);
		rd(OP_RD_NTR, 1'b1, 16'h7fff, "falling mask top bit dropped");
		i_ques_cond = 15'h0002;
		cycles(5);
		rd(OP_RD_EVT, 1'b1, 16'h0000, "rising masked off");
		i_ques_cond = 15'h0000;
		cycles(5);
		cmd(OP_WR_ENA, 1'b1, 16'h0002);
		cycles(2);
		check({15'h0000, o_ques_sum}, 16'h0001, "questionable summary");
		rd(OP_RD_EVT, 1'b1, 16'h0002, "falling event");
		cycles(2);
		check({15'h0000, o_ques_sum}, 16'h0000, "questionable summary cleared");
		$display("test fall done");
	endtask : t_fall

	task automatic t_sum;
		i_oper_cond = 15'h0008;
		cycles(5);
		i_oper_cond = 15'h0000;
		cmd(OP_WR_ENA, 1'b0, 16'h0008);
		cycles(2);
		check({15'h0000, o_oper_sum}, 16'h0001, "summary enabled");
		check({15'h0000, o_ques_sum}, 16'h0000, "other summary idle");
		cmd(OP_WR_ENA, 1'b0, 16'h0004);
		cycles(2);
		check({15'h0000, o_oper_sum}, 16'h0000, "summary masked");
		cmd(OP_WR_ENA, 1'b0, 16'h0008);
		rd(OP_RD_EVT, 1'b0, 16'h0008, "event before clear");
		cycles(2);
		check({15'h0000, o_oper_sum}, 16'h0000, "summary after clear");
		$display("test summary done");
	endtask : t_sum

	task automatic t_preset;
		cmd(OP_WR_PTR, 1'b0, 16'h0001);
		cmd(OP_WR_NTR, 1'b0, 16'h0005);
		cmd(OP_WR_ENA, 1'b1, 16'h0003);
		cmd(OP_PRESET, 1'b0, 16'h0000);
		for (int q = 0; q < 2; q++) begin
			rd(OP_RD_PTR, q[0], 16'hffff, "rising mask preset");
			rd(OP_RD_NTR, q[0], 16'h0000, "falling mask preset");
			rd(OP_RD_ENA, q[0], 16'h0000, "enable preset");
		end
		$display("test preset done");
	endtask : t_preset

	task automatic t_inst_rst;
		cmd(OP_WR_ENA, 1'b0, 16'h0010);
		cmd(OP_WR_NTR, 1'b1, 16'h0020);
		i_oper_cond = 15'h0010;
		cycles(5);
		cmd(OP_INST_RST, 1'b0, 16'h0000);
		check({15'h0000, o_oper_sum}, 16'h0001, "summary kept");
		rd(OP_RD_ENA, 1'b0, 16'h0010, "enable kept");
		rd(OP_RD_NTR, 1'b1, 16'h0020, "falling mask kept");
		rd(OP_RD_PTR, 1'b0, 16'hffff, "rising mask kept");
		rd(OP_RD_COND, 1'b0, 16'h0010, "condition kept");
		rd(OP_RD_EVT, 1'b0, 16'h0010, "event kept");
		i_oper_cond = 15'h0000;
		$display("test instrument reset done");
	endtask : t_inst_rst

	task automatic t_errq;
		rd(OP_RD_ERR, 1'b0, 16'h0000, "empty queue read");
		// One more than fits: the last entry is dropped
		for (int k = 0; k <= DEPTH; k++) begin
			push(err_code_t'(code_of(k)));
		end
		check({15'h0000, o_err_full}, 16'h0001, "queue full");
		for (int k = 0; k < DEPTH; k++) begin
			rd(OP_RD_ERR, 1'b0, code_of(k), "oldest entry signed");
		end
		check({15'h0000, o_err_empty}, 16'h0001, "queue drained");
		rd(OP_RD_ERR, 1'b0, 16'h0000, "no error after drain");
		// Read right behind a single push: entry is readable the next cycle
		@(posedge i_ref_clk);
		#1;
		i_err_push = 1'b1;
		i_err_code = 16'hff23;
		@(posedge i_ref_clk);
		#1;
		i_err_push = 1'b0;
		i_cmd_valid = 1'b1;
		i_cmd_op = OP_RD_ERR;
		@(posedge i_ref_clk);
		#1;
		i_cmd_valid = 1'b0;
		i_cmd_op = OP_NONE;
		check({15'h0000, o_resp_valid}, 16'h0001, "back to back answer");
		check(o_resp_data, 16'hff23, "negative code back to back");
		check({15'h0000, o_err_empty}, 16'h0001, "single entry removed");
		$display("test error queue done");
	endtask : t_errq

	task automatic close_out;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	// Whole run is under two hundred cycles; this is over twenty times that
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		repeat (20) @(posedge i_ref_clk);
		#1;
		i_sys_rst = 1'b0;
		t_reset();
		t_rise();
		t_fall();
		t_sum();
		t_preset();
		t_inst_rst();
		t_errq();
		close_out();
	end
endmodule : status_event_reporting_tb
